// ===== design/lpef_event_flags.v
// link/phy event flag register with interrupt enable mirror
// assumes event inputs are one-cycle pulses or levels from mclk logic,
// except phy_irq which arrives from a pin and is synchronised here
//
// Operation
// RL1 - set bit 18 on a received write to the command reset register
// RL2 - set bit 17 when bus idle for a subaction gap
// RL3 - set bit 16 when bus idle for an arbitration reset gap
// RL4 - set bit 15 when the phy signals an interrupt
// RL5 - phy interrupts on loop, low power, arbitration timeout, unplug
// RL6 - phy takes 166 to 500 us to report, flag is not instant
// RL7 - set bit 14 when a phy register value arrives
// RL8 - set bit 13 when a bus reset begins
// RL9 - bus reset start clears node identifier valid
// RL10 - set bit 11 when receiver commits data to the receive queue
// RL11 - set bit 10 on bad data while iso transmit queue selected
// RL12 - set bit 9 on async format loss; only transmitter reset clears; here the bit also needs a written one after the reset
// RL13 - set bit 8 when a busy ack is sent on receive overflow
// RL14 - set bit 7 on header crc error
// RL15 - set bit 6 on invalid transaction code at transmit queue
// RL16 - set bit 5 when cycle start to fair gap exceeds 125 us
// RL17 - cycle overrun disables cycle master enable
// RL18 - writing one to a set bit clears it; other writes ignored
// RL19 - enable register gates each bit onto the interrupt
// RL20 - software clears then sets cycle master enable to restart
// RL21 - interrupt asserts when any enabled status bit is set
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "lpef_consts.vh"

module lpef_event_flags (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire cmd_reset_rx,
	input wire bus_idle_subact_gap,
	input wire bus_idle_arb_gap,
	input wire phy_irq,
	input wire phy_reg_rx,
	input wire bus_reset_begin,
	input wire rx_queue_commit,
	input wire tx_bad_data,
	input wire iso_tx_queue,
	input wire async_tx_format_loss,
	input wire rx_busy_ack,
	input wire rx_hdr_crc_err,
	input wire tx_bad_tcode,
	input wire cycle_start_seen,
	input wire fair_gap_seen,
	output wire irq,
	output wire cycle_master_enable,
	output wire node_id_valid,
	output wire tx_reset
);

	//****************************************************
	// registers
	//****************************************************
	// one flip-flop per event flag, named after the field it holds
	reg command_reset_flag_ff;
	reg nxt_command_reset_flag;
	reg subaction_gap_flag_ff;
	reg nxt_subaction_gap_flag;
	reg arb_reset_gap_flag_ff;
	reg nxt_arb_reset_gap_flag;
	reg phy_event_flag_ff;
	reg nxt_phy_event_flag;
	reg phy_reg_arrived_flag_ff;
	reg nxt_phy_reg_arrived_flag;
	reg bus_reset_start_flag_ff;
	reg nxt_bus_reset_start_flag;
	reg rx_queue_filled_flag_ff;
	reg nxt_rx_queue_filled_flag;
	reg iso_tx_stuck_flag_ff;
	reg nxt_iso_tx_stuck_flag;
	reg async_tx_stuck_flag_ff;
	reg nxt_async_tx_stuck_flag;
	reg busy_ack_sent_flag_ff;
	reg nxt_busy_ack_sent_flag;
	reg header_crc_err_flag_ff;
	reg nxt_header_crc_err_flag;
	reg tcode_err_flag_ff;
	reg nxt_tcode_err_flag;
	reg cycle_overrun_flag_ff;
	reg nxt_cycle_overrun_flag;
	wire [31:0] status_word;
	reg [31:0] enable_ff;
	reg cm_en_ff;
	reg nxt_cm_en;
	reg id_valid_ff;
	reg nxt_id_valid;
	reg tx_rst_ff;
	reg async_stuck_ff;
	reg nxt_async_stuck;
	reg phy_sync1_ff;
	reg phy_sync2_ff;
	reg phy_prev_ff;
	reg in_cycle_ff;
	reg nxt_in_cycle;
	reg [15:0] cyc_cnt_ff;
	reg [15:0] nxt_cyc_cnt;
	reg overrun_pulse;
	reg [31:0] ev;
	reg [31:0] ack;

	localparam [15:0] CYC_LIMIT = `LPEF_CYCLE_LIMIT_CYC;

	function wr_hit;
		input [7:0] a;
		input [7:0] ofs;
		input we;
		begin
			wr_hit = we && (a == ofs);
		end
	endfunction

	// a new event beats a same-cycle acknowledge [RL18]
	function flag_next;
		input cur;
		input set;
		input ack_bit;
		begin
			flag_next = set | (cur & ~ack_bit);
		end
	endfunction

	//****************************************************
	// register port decode
	//****************************************************
	wire wr_status;
	wire wr_enable;
	wire wr_ctrl;

	assign wr_status = wr_hit(reg_addr, `LPEF_OFS_STATUS, reg_wr);
	assign wr_enable = wr_hit(reg_addr, `LPEF_OFS_ENABLE, reg_wr);
	assign wr_ctrl = wr_hit(reg_addr, `LPEF_OFS_CTRL, reg_wr);

	assign cycle_master_enable = cm_en_ff;
	assign node_id_valid = id_valid_ff;
	assign tx_reset = tx_rst_ff;
	assign irq = |(status_word & enable_ff); // [RL19] [RL21]

	//****************************************************
	// status word as software sees it
	//****************************************************
	// bit 12 and bits outside 18..5 are not implemented and read zero
	assign status_word = {
		13'h0000,
		command_reset_flag_ff,
		subaction_gap_flag_ff,
		arb_reset_gap_flag_ff,
		phy_event_flag_ff,
		phy_reg_arrived_flag_ff,
		bus_reset_start_flag_ff,
		1'b0,
		rx_queue_filled_flag_ff,
		iso_tx_stuck_flag_ff,
		async_tx_stuck_flag_ff,
		busy_ack_sent_flag_ff,
		header_crc_err_flag_ff,
		tcode_err_flag_ff,
		cycle_overrun_flag_ff,
		5'h00
	};

	//****************************************************
	// phy interrupt pin synchroniser
	//****************************************************
	// the phy may take 166-500 us to raise this, no timing assumed [RL6]
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phy_sync1_ff <= 1'b0;
			phy_sync2_ff <= 1'b0;
			phy_prev_ff <= 1'b0;
		end else begin
			phy_sync1_ff <= phy_irq;
			phy_sync2_ff <= phy_sync1_ff;
			phy_prev_ff <= phy_sync2_ff;
		end
	end

	//****************************************************
	// cycle overrun timer
	//****************************************************
	// counts from cycle start until the next fair gap
	always @* begin
		nxt_in_cycle = in_cycle_ff;
		nxt_cyc_cnt = cyc_cnt_ff;
		overrun_pulse = 1'b0;
		if (cycle_start_seen) begin
			nxt_in_cycle = 1'b1;
			nxt_cyc_cnt = 16'h0000;
		end else if (in_cycle_ff) begin
			if (fair_gap_seen) begin
				nxt_in_cycle = 1'b0;
			end else if (cyc_cnt_ff >= CYC_LIMIT) begin
				overrun_pulse = 1'b1; // [RL16]
				nxt_in_cycle = 1'b0;
			end else begin
				nxt_cyc_cnt = cyc_cnt_ff + 16'h0001;
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			in_cycle_ff <= 1'b0;
			cyc_cnt_ff <= 16'h0000;
		end else begin
			in_cycle_ff <= nxt_in_cycle;
			cyc_cnt_ff <= nxt_cyc_cnt;
		end
	end

	//****************************************************
	// event collection and status update
	//****************************************************
	always @* begin
		ev = 32'h0000_0000;
		ev[`LPEF_BIT_CMD_RESET] = cmd_reset_rx; // [RL1]
		ev[`LPEF_BIT_SUBACT_GAP] = bus_idle_subact_gap; // [RL2]
		ev[`LPEF_BIT_ARB_GAP] = bus_idle_arb_gap; // [RL3]
		// rising edge of the synchronised phy line [RL4] [RL5]
		ev[`LPEF_BIT_PHY_EVENT] = phy_sync2_ff & ~phy_prev_ff;
		ev[`LPEF_BIT_PHY_REG] = phy_reg_rx; // [RL7]
		ev[`LPEF_BIT_BUS_RESET] = bus_reset_begin; // [RL8]
		ev[`LPEF_BIT_RX_FILLED] = rx_queue_commit; // [RL10]
		ev[`LPEF_BIT_ISO_STUCK] = tx_bad_data & iso_tx_queue; // [RL11]
		// held while stuck so acks cannot remove it [RL12]
		ev[`LPEF_BIT_ASYNC_STUCK] = async_stuck_ff;
		ev[`LPEF_BIT_BUSY_ACK] = rx_busy_ack; // [RL13]
		ev[`LPEF_BIT_HDR_CRC] = rx_hdr_crc_err; // [RL14]
		ev[`LPEF_BIT_TCODE] = tx_bad_tcode; // [RL15]
		ev[`LPEF_BIT_CYC_OVERRUN] = overrun_pulse; // [RL16]
		ack = 32'h0000_0000;
		if (wr_status) begin
			ack = reg_wdata;
		end
		// per flag: event sets, a written one clears, set wins [RL18]
		nxt_command_reset_flag = flag_next(command_reset_flag_ff,
			ev[`LPEF_BIT_CMD_RESET], ack[`LPEF_BIT_CMD_RESET]);
		nxt_subaction_gap_flag = flag_next(subaction_gap_flag_ff,
			ev[`LPEF_BIT_SUBACT_GAP], ack[`LPEF_BIT_SUBACT_GAP]);
		nxt_arb_reset_gap_flag = flag_next(arb_reset_gap_flag_ff,
			ev[`LPEF_BIT_ARB_GAP], ack[`LPEF_BIT_ARB_GAP]);
		nxt_phy_event_flag = flag_next(phy_event_flag_ff,
			ev[`LPEF_BIT_PHY_EVENT], ack[`LPEF_BIT_PHY_EVENT]);
		nxt_phy_reg_arrived_flag = flag_next(phy_reg_arrived_flag_ff,
			ev[`LPEF_BIT_PHY_REG], ack[`LPEF_BIT_PHY_REG]);
		nxt_bus_reset_start_flag = flag_next(bus_reset_start_flag_ff,
			ev[`LPEF_BIT_BUS_RESET], ack[`LPEF_BIT_BUS_RESET]);
		nxt_rx_queue_filled_flag = flag_next(rx_queue_filled_flag_ff,
			ev[`LPEF_BIT_RX_FILLED], ack[`LPEF_BIT_RX_FILLED]);
		nxt_iso_tx_stuck_flag = flag_next(iso_tx_stuck_flag_ff,
			ev[`LPEF_BIT_ISO_STUCK], ack[`LPEF_BIT_ISO_STUCK]);
		nxt_async_tx_stuck_flag = flag_next(async_tx_stuck_flag_ff,
			ev[`LPEF_BIT_ASYNC_STUCK], ack[`LPEF_BIT_ASYNC_STUCK]);
		nxt_busy_ack_sent_flag = flag_next(busy_ack_sent_flag_ff,
			ev[`LPEF_BIT_BUSY_ACK], ack[`LPEF_BIT_BUSY_ACK]);
		nxt_header_crc_err_flag = flag_next(header_crc_err_flag_ff,
			ev[`LPEF_BIT_HDR_CRC], ack[`LPEF_BIT_HDR_CRC]);
		nxt_tcode_err_flag = flag_next(tcode_err_flag_ff,
			ev[`LPEF_BIT_TCODE], ack[`LPEF_BIT_TCODE]);
		nxt_cycle_overrun_flag = flag_next(cycle_overrun_flag_ff,
			ev[`LPEF_BIT_CYC_OVERRUN], ack[`LPEF_BIT_CYC_OVERRUN]);
	end

	// async stuck condition, cleared only by transmitter reset
	always @* begin
		nxt_async_stuck = async_stuck_ff;
		if (async_tx_format_loss) begin
			nxt_async_stuck = 1'b1; // [RL12]
		end else if (tx_rst_ff) begin
			nxt_async_stuck = 1'b0; // [RL12]
		end
	end

	// control bits: cycle master enable and node id valid
	always @* begin
		nxt_cm_en = cm_en_ff;
		nxt_id_valid = id_valid_ff;
		if (wr_ctrl) begin
			nxt_cm_en = reg_wdata[`LPEF_BIT_CM_EN]; // [RL20]
			nxt_id_valid = reg_wdata[`LPEF_BIT_NODE_ID_VALID];
		end
		// hardware events take priority over a software write
		if (overrun_pulse) begin
			nxt_cm_en = 1'b0; // [RL17]
		end
		if (bus_reset_begin) begin
			nxt_id_valid = 1'b0; // [RL9]
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			command_reset_flag_ff <= 1'b0;
			subaction_gap_flag_ff <= 1'b0;
			arb_reset_gap_flag_ff <= 1'b0;
			phy_event_flag_ff <= 1'b0;
			phy_reg_arrived_flag_ff <= 1'b0;
			bus_reset_start_flag_ff <= 1'b0;
			rx_queue_filled_flag_ff <= 1'b0;
			iso_tx_stuck_flag_ff <= 1'b0;
			async_tx_stuck_flag_ff <= 1'b0;
			busy_ack_sent_flag_ff <= 1'b0;
			header_crc_err_flag_ff <= 1'b0;
			tcode_err_flag_ff <= 1'b0;
			cycle_overrun_flag_ff <= 1'b0;
			enable_ff <= `LPEF_RESET_VAL;
			cm_en_ff <= 1'b0;
			id_valid_ff <= 1'b0;
			tx_rst_ff <= 1'b0;
			async_stuck_ff <= 1'b0;
		end else begin
			command_reset_flag_ff <= nxt_command_reset_flag;
			subaction_gap_flag_ff <= nxt_subaction_gap_flag;
			arb_reset_gap_flag_ff <= nxt_arb_reset_gap_flag;
			phy_event_flag_ff <= nxt_phy_event_flag;
			phy_reg_arrived_flag_ff <= nxt_phy_reg_arrived_flag;
			bus_reset_start_flag_ff <= nxt_bus_reset_start_flag;
			rx_queue_filled_flag_ff <= nxt_rx_queue_filled_flag;
			iso_tx_stuck_flag_ff <= nxt_iso_tx_stuck_flag;
			async_tx_stuck_flag_ff <= nxt_async_tx_stuck_flag;
			busy_ack_sent_flag_ff <= nxt_busy_ack_sent_flag;
			header_crc_err_flag_ff <= nxt_header_crc_err_flag;
			tcode_err_flag_ff <= nxt_tcode_err_flag;
			cycle_overrun_flag_ff <= nxt_cycle_overrun_flag;
			async_stuck_ff <= nxt_async_stuck;
			cm_en_ff <= nxt_cm_en;
			id_valid_ff <= nxt_id_valid;
			// transmitter reset is a self-clearing one-cycle pulse
			tx_rst_ff <= wr_ctrl & reg_wdata[`LPEF_BIT_TX_RESET];
			if (wr_enable) begin
				enable_ff <= reg_wdata & `LPEF_STATUS_MASK; // [RL19]
			end
		end
	end

	//****************************************************
	// read port
	//****************************************************
	// unmapped addresses read as zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`LPEF_OFS_STATUS: reg_rdata <= status_word;
				`LPEF_OFS_ENABLE: reg_rdata <= enable_ff;
				`LPEF_OFS_CTRL: reg_rdata <= {29'h0000_0000, 1'b0,
					id_valid_ff, cm_en_ff};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule // lpef_event_flags

// ===== design/lpef_consts.vh
// constants for the link/phy event flag block
// assumes a 250 MHz mclk and a plain strobe register port
`ifndef LPEF_CONSTS_VH
`define LPEF_CONSTS_VH

// register offsets (byte addresses)
`define LPEF_OFS_STATUS 8'h08
`define LPEF_OFS_ENABLE 8'h0c
`define LPEF_OFS_CTRL 8'h18

// status field positions
`define LPEF_BIT_CMD_RESET 18
`define LPEF_BIT_SUBACT_GAP 17
`define LPEF_BIT_ARB_GAP 16
`define LPEF_BIT_PHY_EVENT 15
`define LPEF_BIT_PHY_REG 14
`define LPEF_BIT_BUS_RESET 13
`define LPEF_BIT_RX_FILLED 11
`define LPEF_BIT_ISO_STUCK 10
`define LPEF_BIT_ASYNC_STUCK 9
`define LPEF_BIT_BUSY_ACK 8
`define LPEF_BIT_HDR_CRC 7
`define LPEF_BIT_TCODE 6
`define LPEF_BIT_CYC_OVERRUN 5

// implemented status bits 18..5 except 12
`define LPEF_STATUS_MASK 32'h0007_efe0
`define LPEF_RESET_VAL 32'h0000_0000

// control register fields
`define LPEF_BIT_CM_EN 0
`define LPEF_BIT_NODE_ID_VALID 1
`define LPEF_BIT_TX_RESET 2

// cycle overrun limit
`define LPEF_CYCLE_LIMIT_NS 125000
`define LPEF_CLK_PERIOD_NS 4
// the ratio above, sized to fit the 16-bit cycle counter
`define LPEF_CYCLE_LIMIT_CYC 16'h7a12

`endif

// ===== test/lpef_phy_model.sv
// phy side model: raises its interrupt pin a while after a cable fault
// assumes fault is a level from the bench; report delay is shortened
`timescale 1ns/1ps
module lpef_phy_model #(parameter int REPORT_NS = 200) (
	input wire logic fault,
	output logic phy_irq
);
	// loop, low power, arbitration timeout and unplug all look alike here
	initial phy_irq = 1'b0;
	always @(posedge fault) begin
		#REPORT_NS phy_irq = 1'b1;
		#100 phy_irq = 1'b0;
	end
endmodule // lpef_phy_model

// ===== test/lpef_checker.sv
// assertions on the event flag block ports
// assumes a bind onto lpef_event_flags
`timescale 1ns/1ps
module lpef_checker (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire bus_reset_begin,
	input wire cycle_start_seen,
	input wire fair_gap_seen,
	input wire irq,
	input wire cycle_master_enable,
	input wire node_id_valid,
	input wire tx_reset
);
	logic [15:0] run_ff;
	wire ctl_wr = reg_wr && reg_addr == 8'h18;
	// a control write clears the watch until the next cycle start, so restarts never false-fire
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n || fair_gap_seen || ctl_wr)
			run_ff <= 16'h0000;
		else if (cycle_start_seen)
			run_ff <= 16'h0001;
		else if (run_ff != 16'h0000 && run_ff != 16'hffff)
			run_ff <= run_ff + 16'h0001;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	en_mask_a: assert property ($past(reg_rd && reg_addr == 8'h0c) |->
		(reg_rdata & 32'hfff8_101f) == 32'h0000_0000) else $error("enable bits");
	niv_clear_a: assert property (bus_reset_begin |=> !node_id_valid)
		else $error("node id kept");
	overrun_a: assert property (run_ff > 16'h7a1c |-> !cycle_master_enable)
		else $error("cycle master kept");
	cm_restart_a: assert property ($rose(cycle_master_enable) |->
		$past(ctl_wr && reg_wdata[0])) else $error("cycle master rose");
	txr_pulse_a: assert property (tx_reset |=> !tx_reset)
		else $error("tx reset long");
	txr_cause_a: assert property ($rose(tx_reset) |->
		$past(ctl_wr && reg_wdata[2])) else $error("tx reset cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
		else $error("irq fell alone");
	irq_src_a: assert property ($past(reg_rd && reg_addr == 8'h08 && irq)
		|-> reg_rdata != 32'h0000_0000) else $error("irq without status");
	cover property (bus_reset_begin ##1 !node_id_valid);
	cover property ($fell(cycle_master_enable));
	cover property ($rose(irq));
endmodule // lpef_checker

// ===== test/test_lpef_event_flags.sv
// self-checking bench for the event flag block
// assumes the phy model and the bound checker
`timescale 1ns/1ps
module test_lpef_event_flags;
	logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, iso = 0, flt = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [12:0] ev = 13'h0000;
	wire [31:0] rdata;
	wire irq, cme, niv, txr, phy_irq;
	int error_cnt = 0, n_checks = 0;
	int pos[11] = '{18, 17, 16, 14, 13, 11, 10, 9, 8, 7, 6};
	always #2 mclk = ~mclk;
	lpef_phy_model lpef_phy_model_inst (.fault(flt), .phy_irq(phy_irq));
	lpef_event_flags lpef_event_flags_inst (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdata), .cmd_reset_rx(ev[0]), .bus_idle_subact_gap(ev[1]),
		.bus_idle_arb_gap(ev[2]), .phy_irq(phy_irq), .phy_reg_rx(ev[3]),
		.bus_reset_begin(ev[4]), .rx_queue_commit(ev[5]), .tx_bad_data(ev[6]),
		.iso_tx_queue(iso), .async_tx_format_loss(ev[7]),
		.rx_busy_ack(ev[8]), .rx_hdr_crc_err(ev[9]), .tx_bad_tcode(ev[10]),
		.cycle_start_seen(ev[11]), .fair_gap_seen(ev[12]), .irq(irq),
		.cycle_master_enable(cme), .node_id_valid(niv), .tx_reset(txr));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd <= 1;
		addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		#1 chk(rdata, exp);
	endtask
	task pe(input int i);
		@(posedge mclk);
		ev[i] <= 1;
		@(posedge mclk);
		ev[i] <= 0;
	endtask
	task results;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		rd(8'h08, 32'h0000_0000);
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
		wr(8'h0c, 32'hffff_ffff);
		rd(8'h0c, 32'h0007_efe0);
		pe(6);
		rd(8'h08, 32'h0000_0000);
		@(posedge mclk);
		iso <= 1;
		$display("test access done");
		for (int i = 0; i < 11; i++) begin
			pe(i);
			// the stuck latch sits between event and flag: one cycle more
			if (i == 7) @(posedge mclk);
			#1 chk(irq, 1);
			rd(8'h08, 32'h0000_0001 << pos[i]);
			wr(8'h08, 32'h0000_0001 << pos[i]);
			if (i == 7) begin
				rd(8'h08, 32'h0000_0200);
				wr(8'h18, 32'h0000_0004);
				#1 chk(txr, 1);
				wr(8'h08, 32'h0000_0200);
			end
			rd(8'h08, 32'h0000_0000);
			chk(irq, 0);
		end
		wr(8'h0c, 32'h0000_0000);
		pe(9);
		#1 chk(irq, 0);
		rd(8'h08, 32'h0000_0080);
		wr(8'h0c, 32'h0000_0080);
		#1 chk(irq, 1);
		wr(8'h08, 32'h0000_0080);
		wr(8'h18, 32'h0000_0002);
		#1 chk(niv, 1);
		pe(4);
		#1 chk(niv, 0);
		wr(8'h08, 32'h0000_2000);
		$display("test flags done");
		wr(8'h0c, 32'h0000_8000);
		@(posedge mclk);
		flt <= 1;
		for (int k = 0; k < 500 && irq !== 1; k++) @(posedge mclk);
		rd(8'h08, 32'h0000_8000);
		wr(8'h08, 32'h0000_8000);
		wr(8'h18, 32'h0000_0001);
		pe(11);
		repeat (100) @(posedge mclk);
		pe(12);
		rd(8'h08, 32'h0000_0000);
		pe(11);
		repeat (31260) @(posedge mclk);
		rd(8'h08, 32'h0000_0020);
		chk(cme, 0);
		pe(12);
		wr(8'h18, 32'h0000_0000);
		wr(8'h18, 32'h0000_0001);
		#1 chk(cme, 1);
		$display("test cycle done");
		results;
	end
	initial begin
		#400000;
		error_cnt++;
		results;
	end
endmodule // test_lpef_event_flags
bind lpef_event_flags lpef_checker lpef_checker_inst (.mclk(mclk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_reset_begin(bus_reset_begin),
	.cycle_start_seen(cycle_start_seen),
	.fair_gap_seen(fair_gap_seen), .irq(irq),
	.cycle_master_enable(cycle_master_enable),
	.node_id_valid(node_id_valid), .tx_reset(tx_reset));
